/* core/pwmdt_top.sv */
// Dead-time PWM block with AHB-Lite register slave
//
// The register offsets and register access over AHB-Lite were decided locally.
`default_nettype none
module pwmdt_top
  import pwmdt_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic [5:0]       pwm_out,
  output logic             period_irq
);
  typedef struct packed {
    logic [7:0]                                dtc;
    logic [PWMDT_PAIRS-1:0]                    pmode;
    logic [1:0]                                tmode;
    logic [1:0]                                tps;
    logic                                      irq_en;
    logic                                      en;
    logic                                      run;
    logic [PWMDT_TB_W-1:0]                     per;
    logic [PWMDT_PAIRS-1:0][PWMDT_DUTY_W-1:0]  duty;
    logic [5:0]                                ovsel;
    logic [5:0]                                ovst;
    logic                                      wpend;
    logic [7:0]                                waddr;
    logic [31:0]                               rdata;
    logic                                      dt_wr;
    logic [5:0]                                pins;
    logic                                      irq;
    logic                                      rdy;
  } pwmdt_top_st_t;

  pwmdt_top_st_t          s_r;
  pwmdt_top_st_t          s_nxt;
  pwmdt_q_t               q_phase;
  logic [PWMDT_TB_W-1:0]  tb_cnt;
  logic                   tb_pm;
  logic                   one_to_one;
  logic                   single;
  logic [PWMDT_PAIRS-1:0] cmp_raw;
  logic [PWMDT_PAIRS-1:0] cmp_eff;
  logic [PWMDT_PAIRS-1:0] dt_hi;
  logic [PWMDT_PAIRS-1:0] dt_lo;
  logic [5:0]             pins_c;
  logic                   addr_ok;

  pwmdt_dt_if dt_bus ();

  // Edge-aligned compare: active from count zero until duty match
  function automatic logic duty_active(input logic [PWMDT_TB_W-1:0] cnt,
                                       input pwmdt_q_t q,
                                       input logic [PWMDT_DUTY_W-1:0] duty,
                                       input logic one);
    if (one) return {cnt, q} < duty;
    return cnt < duty[PWMDT_DUTY_W-1:2];
  endfunction

  function automatic logic [31:0] rd_mux(input pwmdt_top_st_t st,
                                         input logic [7:0] a,
                                         input logic [PWMDT_TB_W-1:0] cnt,
                                         input pwmdt_q_t q);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      OFS_DTC:    v[7:0] = st.dtc;
      OFS_PWMC0:  v[PWMDT_PAIRS-1:0] = st.pmode;
      OFS_TBC0: begin
        v[TBC_MODE_LO +: 2] = st.tmode;
        v[TBC_PS_LO +: 2]   = st.tps;
        v[TBC_IRQEN]        = st.irq_en;
        v[TBC_EN]           = st.en;
      end
      OFS_PER:    v[PWMDT_TB_W-1:0] = st.per;
      OFS_DUTY0:  v[PWMDT_DUTY_W-1:0] = st.duty[0];
      OFS_DUTY1:  v[PWMDT_DUTY_W-1:0] = st.duty[1];
      OFS_DUTY2:  v[PWMDT_DUTY_W-1:0] = st.duty[2];
      OFS_OVSEL:  v[5:0] = st.ovsel;
      OFS_OVST:   v[5:0] = st.ovst;
      OFS_STATUS: begin
        v[PWMDT_TB_W-1:0]  = cnt;
        v[ST_Q_LO +: 2]    = q;
        v[ST_PINS_LO +: 6] = st.pins;
      end
      default:    v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  pwmdt_timebase u_tb (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .enable       (s_r.run),
    .prescale     (s_r.tps),
    .period       (s_r.per),
    .q_phase      (q_phase),
    .counter      (tb_cnt),
    .period_match (tb_pm)
  );

  assign one_to_one            = s_r.tps == TB_PS_1TO1;
  assign single                = s_r.tmode == TB_MODE_SINGLE;
  assign dt_bus.q_phase        = q_phase;
  assign dt_bus.tb_one_to_one  = one_to_one;
  assign dt_bus.prescale_sel   = s_r.dtc[DTC_PS_LO +: 2];
  assign dt_bus.dt_count       = s_r.dtc[5:0];
  assign dt_bus.dt_wr          = s_r.dt_wr;

  for (genvar p = 0; p < PWMDT_PAIRS; p++) begin : g_pair
    assign cmp_raw[p] = s_r.run && duty_active(tb_cnt, q_phase, s_r.duty[p], one_to_one);
    // Odd-pin override steers the complementary pair before dead time
    assign cmp_eff[p] = (s_r.pmode[p] || s_r.ovsel[2*p+1]) ? cmp_raw[p] : s_r.ovst[2*p+1];

    pwmdt_deadtime u_dt (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .dt        (dt_bus.unit),
      .cmp       (cmp_eff[p]),
      .pair_mode (s_r.pmode[p]),
      .hi        (dt_hi[p]),
      .lo        (dt_lo[p])
    );
  end

  always_comb begin
    for (int p = 0; p < PWMDT_PAIRS; p++) begin
      if (s_r.pmode[p]) begin
        pins_c[2*p+1] = s_r.ovsel[2*p+1] ? dt_hi[p] : s_r.ovst[2*p+1];
        pins_c[2*p]   = s_r.ovsel[2*p] ? dt_lo[p] : s_r.ovst[2*p];
      end else begin
        pins_c[2*p+1] = dt_hi[p];
        pins_c[2*p]   = dt_lo[p];
      end
    end
    if (single && !s_r.en) pins_c = 6'h00;
  end

  assign addr_ok = hsel && htrans[1] && hready;

  always_comb begin
    s_nxt = s_r;
    s_nxt.dt_wr = 1'b0;
    s_nxt.irq = 1'b0;
    s_nxt.pins = pins_c;
    if (tb_pm && single) begin
      s_nxt.en = 1'b0;
      s_nxt.irq = s_r.irq_en;
    end
    // Data phase of a write; a write that sets enable beats the hardware clear
    if (s_r.wpend) begin
      unique case (s_r.waddr)
        OFS_DTC: begin
          s_nxt.dtc = hwdata[7:0];
          s_nxt.dt_wr = 1'b1;
        end
        OFS_PWMC0: s_nxt.pmode = hwdata[PWMDT_PAIRS-1:0];
        OFS_TBC0: begin
          s_nxt.tmode  = hwdata[TBC_MODE_LO +: 2];
          s_nxt.tps    = hwdata[TBC_PS_LO +: 2];
          s_nxt.irq_en = hwdata[TBC_IRQEN];
          s_nxt.en     = hwdata[TBC_EN];
        end
        OFS_PER:   s_nxt.per = hwdata[PWMDT_TB_W-1:0];
        OFS_DUTY0: s_nxt.duty[0] = hwdata[PWMDT_DUTY_W-1:0];
        OFS_DUTY1: s_nxt.duty[1] = hwdata[PWMDT_DUTY_W-1:0];
        OFS_DUTY2: s_nxt.duty[2] = hwdata[PWMDT_DUTY_W-1:0];
        OFS_OVSEL: s_nxt.ovsel = hwdata[5:0];
        OFS_OVST:  s_nxt.ovst = hwdata[5:0];
        default:   s_nxt.dtc = s_r.dtc;
      endcase
    end
    // Time base starts at Q1 so every pulse has the same phase alignment
    s_nxt.run = s_nxt.en && (s_r.run || q_phase == PWMDT_Q4);
    s_nxt.wpend = addr_ok && hwrite;
    s_nxt.waddr = haddr[7:0];
    // Read sees any write completing in the same cycle
    if (addr_ok && !hwrite) s_nxt.rdata = rd_mux(s_nxt, haddr[7:0], tb_cnt, q_phase);
    s_nxt.rdy = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r       <= '0;
      s_r.dtc   <= RST_DTC;
      s_r.ovsel <= RST_OVSEL;
      s_r.ovst  <= RST_OVST;
      s_r.rdy   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout  = s_r.rdy;
  assign hresp      = 1'b0;
  assign hrdata     = s_r.rdata;
  assign pwm_out    = s_r.pins;
  assign period_irq = s_r.irq;
endmodule // pwmdt_top
`default_nettype wire

/* shared/pwmdt_pkg.sv */
// Constants, register map and types shared by the dead-time PWM block
`default_nettype none
package pwmdt_pkg;
  localparam int PWMDT_PAIRS  = 3;
  localparam int PWMDT_TB_W   = 12;
  localparam int PWMDT_DUTY_W = 14;

  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0] OFS_DTC    = 8'h00;
  localparam logic [7:0] OFS_PWMC0  = 8'h04;
  localparam logic [7:0] OFS_TBC0   = 8'h08;
  localparam logic [7:0] OFS_PER    = 8'h0c;
  localparam logic [7:0] OFS_DUTY0  = 8'h10;
  localparam logic [7:0] OFS_DUTY1  = 8'h14;
  localparam logic [7:0] OFS_DUTY2  = 8'h18;
  localparam logic [7:0] OFS_OVSEL  = 8'h1c;
  localparam logic [7:0] OFS_OVST   = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // Reset values
  localparam logic [7:0] RST_DTC   = 8'h00;
  localparam logic [5:0] RST_OVSEL = 6'h3f;
  localparam logic [5:0] RST_OVST  = 6'h00;

  // Field positions
  localparam int DTC_PS_LO   = 6;
  localparam int TBC_MODE_LO = 0;
  localparam int TBC_PS_LO   = 2;
  localparam int TBC_IRQEN   = 6;
  localparam int TBC_EN      = 7;
  localparam int ST_Q_LO     = 12;
  localparam int ST_PINS_LO  = 16;

  // Encodings
  localparam logic [1:0] TB_MODE_SINGLE = 2'h1;
  localparam logic [1:0] TB_PS_1TO1     = 2'h0;
  localparam logic [1:0] DT_PS_DIV2     = 2'h0;

  typedef enum logic [1:0] {
    PWMDT_Q1 = 2'b00,
    PWMDT_Q2 = 2'b01,
    PWMDT_Q3 = 2'b10,
    PWMDT_Q4 = 2'b11
  } pwmdt_q_t;
endpackage
`default_nettype wire

/* shared/pwmdt_dt_if.sv */
// Shared dead-time configuration and phase carried to each dead-time unit
`default_nettype none
interface pwmdt_dt_if;
  import pwmdt_pkg::*;
  pwmdt_q_t   q_phase;
  logic       tb_one_to_one;
  logic [1:0] prescale_sel;
  logic [5:0] dt_count;
  logic       dt_wr;
  modport ctl  (output q_phase, output tb_one_to_one, output prescale_sel, output dt_count, output dt_wr);
  modport unit (input q_phase, input tb_one_to_one, input prescale_sel, input dt_count, input dt_wr);
endinterface
`default_nettype wire

/* core/pwmdt_timebase.sv */
// Q phase generator and edge-aligned time-base counter
`default_nettype none
module pwmdt_timebase
  import pwmdt_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  enable,
  input  wire logic [1:0]            prescale,
  input  wire logic [PWMDT_TB_W-1:0] period,
  output var  pwmdt_q_t              q_phase,
  output logic [PWMDT_TB_W-1:0]      counter,
  output logic                       period_match
);
  typedef struct packed {
    pwmdt_q_t              q;
    logic [5:0]            pre;
    logic [PWMDT_TB_W-1:0] cnt;
    logic                  pm;
  } pwmdt_tb_st_t;

  pwmdt_tb_st_t s_r;
  pwmdt_tb_st_t s_nxt;
  logic [5:0]   lim;

  always_comb begin
    // Instruction cycles per count: 1, 4, 16 or 64
    lim = 6'((7'd1 << {prescale, 1'b0}) - 7'd1);
    s_nxt = s_r;
    s_nxt.q = pwmdt_q_t'(s_r.q + 2'd1);
    s_nxt.pm = 1'b0;
    if (!enable) begin
      s_nxt.pre = '0;
      s_nxt.cnt = '0;
    end else if (s_r.q == PWMDT_Q4) begin
      if (s_r.pre != lim) begin
        s_nxt.pre = 6'(s_r.pre + 6'd1);
      end else begin
        s_nxt.pre = '0;
        if (s_r.cnt == period) begin
          s_nxt.cnt = '0;
          s_nxt.pm = 1'b1;
        end else begin
          s_nxt.cnt = PWMDT_TB_W'(s_r.cnt + 1'b1);
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_phase      = s_r.q;
  assign counter      = s_r.cnt;
  assign period_match = s_r.pm;
endmodule // pwmdt_timebase
`default_nettype wire

/* core/pwmdt_deadtime.sv */
// Dead-time unit for one output pair
`default_nettype none
module pwmdt_deadtime
  import pwmdt_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  pwmdt_dt_if.unit  dt,
  input  wire logic cmp,
  input  wire logic pair_mode,
  output logic      hi,
  output logic      lo
);
  typedef struct packed {
    logic       cmp;
    logic [5:0] cnt;
    logic [3:0] pre;
    logic [1:0] mq;
    logic       sup;
    logic       hi;
    logic       lo;
  } pwmdt_dtu_st_t;

  pwmdt_dtu_st_t s_r;
  pwmdt_dtu_st_t s_nxt;
  logic [3:0]    lim;
  logic          ok;

  always_comb begin
    lim = 4'((5'd2 << dt.prescale_sel) - 5'd1);
    if (dt.tb_one_to_one) begin
      if (dt.prescale_sel == DT_PS_DIV2) ok = dt.q_phase[0] == s_r.mq[0];
      else ok = dt.q_phase == s_r.mq;
    end else begin
      if (dt.prescale_sel == DT_PS_DIV2) ok = !dt.q_phase[0];
      else ok = dt.q_phase == PWMDT_Q1;
    end
    s_nxt = s_r;
    s_nxt.cmp = cmp;
    s_nxt.pre = (s_r.pre == lim) ? 4'h0 : 4'(s_r.pre + 4'h1);
    if (dt.dt_wr) s_nxt.pre = 4'h0;
    if (pair_mode) begin
      s_nxt.hi = cmp;
      s_nxt.lo = cmp;
      s_nxt.cnt = 6'h00;
      s_nxt.sup = 1'b0;
    end else if (cmp != s_r.cmp) begin
      s_nxt.cnt = dt.dt_count;
      s_nxt.pre = 4'h0;
      s_nxt.mq = dt.q_phase;
      s_nxt.sup = !cmp && (s_r.cnt != 6'h00);
      s_nxt.hi = 1'b0;
      s_nxt.lo = 1'b0;
      if (dt.dt_count == 6'h00 && !s_nxt.sup) begin
        s_nxt.hi = cmp;
        s_nxt.lo = !cmp;
      end
    end else if (s_r.cnt != 6'h00 && s_r.pre == lim && ok) begin
      s_nxt.cnt = 6'(s_r.cnt - 6'h01);
      if (s_r.cnt == 6'h01 && !s_r.sup) begin
        s_nxt.hi = s_r.cmp;
        s_nxt.lo = !s_r.cmp;
      end
    end else if (s_r.cnt == 6'h00 && !s_r.sup) begin
      s_nxt.hi = s_r.cmp;
      s_nxt.lo = !s_r.cmp;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hi = s_r.hi;
  assign lo = s_r.lo;
endmodule // pwmdt_deadtime
`default_nettype wire

/* test/pwmdt_top_monitor.sv */
// Port-level checker for the dead-time PWM block
`default_nettype none
module pwmdt_top_monitor
  import pwmdt_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [5:0]  pwm_out,
  input wire logic        period_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic       rd;
    logic       rdx;
    logic       wr;
    logic [7:0] wa;
    logic [7:0] dtc;
    logic [2:0] pm;
    logic [9:0] off;
  } pwmdt_mon_t;

  pwmdt_mon_t  s_r;
  pwmdt_mon_t  s_nxt;
  logic        take;
  logic        ovl;
  logic [10:0] dead;

  assign take = hsel && htrans[1] && hready;
  assign ovl  = |(~s_r.pm & {&pwm_out[5:4], &pwm_out[3:2], &pwm_out[1:0]});
  assign dead = 11'({s_r.dtc[5:0], 1'b0}) << s_r.dtc[7:6];

  always_comb begin
    s_nxt     = s_r;
    s_nxt.rd  = take && !hwrite && haddr[7:0] == OFS_DTC;
    s_nxt.rdx = take && !hwrite && haddr[7:0] > OFS_STATUS;
    s_nxt.wr  = take && hwrite;
    if (take) begin
      s_nxt.wa = haddr[7:0];
    end
    if (s_r.wr && s_r.wa == OFS_DTC) begin
      s_nxt.dtc = hwdata[7:0];
    end
    if (s_r.wr && s_r.wa == OFS_PWMC0) begin
      s_nxt.pm = hwdata[2:0];
    end
    // Cycles the low side of pair 0 has been off
    if (pwm_out[0]) begin
      s_nxt.off = 10'h000;
    end else if (s_r.off != 10'h3ff) begin
      s_nxt.off = s_r.off + 10'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  default clocking mcb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  resp_okay_a: assert property (hresp == 1'b0)
    else $error("slave response not OKAY");
  ready_high_a: assert property (hreadyout == 1'b1)
    else $error("wait state inserted");
  dtc_read_a: assert property (s_r.rd |-> hrdata == {24'h000000, s_r.dtc})
    else $error("dead-time control read back wrong");
  unmapped_read_a: assert property (s_r.rdx |-> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  irq_pulse_a: assert property (period_irq |=> !period_irq)
    else $error("period interrupt longer than one cycle");
  pulse_end_a: assert property (period_irq |-> ##[1:4] pwm_out == 6'h00)
    else $error("pins still active after pulse end");
  no_overlap_a: assert property (!ovl)
    else $error("complementary pair both active");
  dead_gap_a: assert property (!s_r.pm[0] && $rose(pwm_out[1]) |-> 11'(s_r.off) + 11'd4 >= dead)
    else $error("dead time shorter than programmed");

  cover property (period_irq);
  cover property (s_r.pm[0] && pwm_out[1:0] == 2'b11);
  cover property (!s_r.pm[0] && $rose(pwm_out[1]));
  cover property (s_r.rdx);
endmodule // pwmdt_top_monitor

bind pwmdt_top pwmdt_top_monitor i_pwmdt_top_monitor (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .pwm_out(pwm_out), .period_irq(period_irq)
);
`default_nettype wire

/* test/pwmdt_bridge.sv */
// Half-bridge stand-in that counts shorted legs
`default_nettype none
module pwmdt_bridge (
  input  wire logic       hclk,
  input  wire logic [5:0] gate,
  input  wire logic [2:0] indep,
  output var  int         shorts
);
  timeunit 1ns;
  timeprecision 1ns;
  initial shorts = 0;
  // Both switches of a complementary leg conducting shorts the supply
  always @(negedge hclk) begin
    for (int k = 0; k < 3; k++) begin
      if (!indep[k] && gate[2 * k] === 1'b1 && gate[2 * k + 1] === 1'b1) begin
        shorts = shorts + 1;
      end
    end
  end
endmodule // pwmdt_bridge
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the dead-time PWM block
`default_nettype none
module tb_top
  import pwmdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, period_irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize, pm;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [5:0]  pwm_out;
  // dead times at most a third of active and idle time
  logic [7:0]  dts [6] = '{8'h03, 8'h43, 8'h83, 8'hc1, 8'h00, 8'h43};
  int          mismatches = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          shorts, g, w, n;

  pwmdt_top i_pwmdt_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pwm_out(pwm_out), .period_irq(period_irq)
  );
  pwmdt_bridge i_pwmdt_bridge (.hclk(hclk), .gate(pwm_out), .indep(pm), .shorts(shorts));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
    n_checks++;
    if (got !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, got);
    end
  endtask

  task automatic bus(input logic wt, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= wt;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(nm, e, rv);
  endtask

  task automatic wpin(input int b, input logic v);
    n = 0;
    while (pwm_out[b] !== v && n < 4000) begin
      @(negedge hclk);
      n++;
    end
  endtask

  // Cycles the low side stays off before the high side turns on
  task automatic gap(output int gc);
    wpin(1, 1'b0);
    wpin(0, 1'b1);
    wpin(0, 1'b0);
    gc = 0;
    while (pwm_out[1] !== 1'b1 && gc < 4000) begin
      @(negedge hclk);
      gc++;
    end
  endtask

  task automatic pulse(output int wd);
    wd = 0;
    n = 0;
    while (period_irq !== 1'b1 && n < 4000) begin
      @(negedge hclk);
      n++;
      if (pwm_out[1] === 1'b1) wd++;
    end
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    pm = 3'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("dtc reset", OFS_DTC, 32'h00000000);
    rdc("ovsel reset", OFS_OVSEL, 32'h0000003f);
    rdc("unmapped", 8'h40, 32'h00000000);
    wr(OFS_DTC, 32'h000000a5);
    rdc("dtc rw", OFS_DTC, 32'h000000a5);
    wr(OFS_PER, 32'h00000028);
    wr(OFS_DUTY0, 32'h00000050);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_TBC0, 32'h00000000);
      wr(OFS_DTC, {24'h000000, dts[i]});
      wr(OFS_TBC0, (i == 5) ? 32'h00000084 : 32'h00000080);
      gap(g);
      w = dts[i][5:0] * (2 << dts[i][7:6]);
      chk("dead gap", 32'h1, 32'(g + 4 >= w && g <= w + 8));
    end
    wr(OFS_TBC0, 32'h00000000);
    wr(OFS_DTC, 32'h000000ff);
    wr(OFS_TBC0, 32'h00000080);
    repeat (20) @(negedge hclk);
    n = 0;
    repeat (1000) begin
      @(negedge hclk);
      if (pwm_out[1:0] !== 2'b00) n++;
    end
    chk("long dead pins", 32'h0, n);
    wr(OFS_TBC0, 32'h00000000);
    wr(OFS_PWMC0, 32'h00000007);
    pm <= 3'h7;
    wr(OFS_DUTY2, 32'h00000050);
    wr(OFS_TBC0, 32'h00000080);
    wpin(0, 1'b1);
    @(negedge hclk);
    chk("indep pins", 32'h33, {26'h0, pwm_out});
    wr(OFS_OVSEL, 32'h0000003c);
    for (int v = 0; v < 4; v++) begin
      wr(OFS_OVST, 32'(v));
      repeat (4) @(negedge hclk);
      chk("override", 32'(v), {30'h0, pwm_out[1:0]});
    end
    wr(OFS_OVSEL, 32'h0000003f);
    wr(OFS_TBC0, 32'h00000000);
    wr(OFS_TBC0, 32'h000000c1);
    pulse(w);
    chk("period irq", 32'h1, {31'h0, period_irq});
    chk("pulse width", 32'h1, 32'(w >= 76 && w <= 84));
    repeat (4) @(negedge hclk);
    chk("pins after pulse", 32'h0, {26'h0, pwm_out});
    rdc("enable cleared", OFS_TBC0, 32'h00000041);
    rdc("period kept", OFS_PER, 32'h00000028);
    wr(OFS_TBC0, 32'h000000c1);
    pulse(g);
    chk("pulse repeat", w, g);
    chk("shorted legs", 32'h0, shorts);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
